// ### rtl/rsu_params.svh
// rsu_params.svh: register indices, field positions, reset values and
// timing figures of the receive signaling unit.
// assumes: included by bare name; definitions only.
`ifndef RSU_PARAMS_SVH
`define RSU_PARAMS_SVH

// =====================================================================
// register indices (byte address = 4 * index)
`define RSU_IDX_COS_INFO   7'h38
`define RSU_IDX_COS_EN     7'h3c
`define RSU_IDX_SIGCTL     7'h40
`define RSU_IDX_PCPTR      7'h50
`define RSU_IDX_PCDATA     7'h51
`define RSU_IDX_STATUS     7'h55
`define RSU_IDX_MASK       7'h56
`define RSU_IDX_CONFIG     7'h57
`define RSU_IDX_RX_SIG     7'h60

// =====================================================================
// fields and reset values
`define RSU_SIGCTL_RST     8'h00
`define RSU_SIGCTL_WMASK   8'h9f
`define RSU_B_ALL_ONES     0
`define RSU_B_TX_ORDER     1
`define RSU_B_RX_ORDER     2
`define RSU_B_FORCE_FRZ    3
`define RSU_B_FRZ_EN       4
`define RSU_B_GLOB_REINS   7
`define RSU_B_REINS_SEL    0
`define RSU_B_ONES_SEL     1
`define RSU_B_T1           0
`define RSU_B_ESF          1
`define RSU_B_INTEG        2
`define RSU_B_BP2048       3
`define RSU_CFG_RST        8'h00
`define RSU_CH_MASK        32'h3fffffff
`define RSU_T1_CH_MASK     32'h00ffffff

// =====================================================================
// framing and timing
`define RSU_NB             120
`define RSU_LEN_T1         8'd192
`define RSU_LEN_2048       8'd255
`define RSU_MF_ESF         5'd23
`define RSU_MF_D4          5'd11
`define RSU_MF_E1          5'd15
`define RSU_INTEG_MF       2'd3
`define RSU_CLK_MHZ        250
`define RSU_HOLD_ESF_US    9000
`define RSU_HOLD_D4_US     4500

`endif

// ### rtl/rsu_pkg.sv
// rsu_pkg: types of the receive signaling unit.
// assumes: compiled before every rtl module.
package rsu_pkg;

  typedef enum logic [1:0] {
    RSU_RUN    = 2'b00,
    RSU_FROZEN = 2'b01,
    RSU_HOLD   = 2'b10
  } rsu_frz_t;

endpackage

// ### rtl/rsu_sync2.sv
// rsu_sync2: two-flop synchroniser for levels from outside i_clk.
// assumes: inputs slow against i_clk.
`timescale 1ns/100ps

module rsu_sync2 #(
  parameter int P_W = 1
) (
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  input  wire logic [P_W-1:0] i_d,
  output logic      [P_W-1:0] o_q
);

  logic [P_W-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule

// ### rtl/rsu_cos_chan.sv
// rsu_cos_chan: per-channel change-of-state detector with optional
// three-multiframe integration.
// assumes: i_mf is a one-cycle pulse at each multiframe boundary.
`timescale 1ns/100ps
`include "rsu_params.svh"

module rsu_cos_chan (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_mf,
  input  wire logic       i_integ,
  input  wire logic [3:0] i_new,
  output logic            o_change
);

  logic [3:0] rep;
  logic [3:0] cand;
  logic [1:0] cnt;

  wire       same     = (i_new == cand);
  wire [1:0] next_cnt = !same ? 2'd1 :
                        (cnt == 2'd3) ? cnt : cnt + 2'd1;
  // integration: value must have held for three boundaries in a row
  wire       settled  = !i_integ || (next_cnt == `RSU_INTEG_MF); // R4
  assign o_change = i_mf && settled && (i_new != rep);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rep  <= 4'h0;
      cand <= 4'h0;
      cnt  <= 2'd0;
    end else if (i_mf) begin
      cand <= i_new;
      cnt  <= next_cnt;
      if (o_change) begin
        rep <= i_new;
      end
    end
  end

endmodule

// ### rtl/rsu_receive_signaling.sv
// rsu_receive_signaling: receive signaling unit of a T1/E1 framer.
// assumes: framer strobes, mf pulse and alarms are on i_clk; backplane
// clock, sync and serial data are asynchronous pins; APB slave, zero wait.
//
// Notes on behaviour
// R1: capture robbed-bit or TS16 signaling; T1 uses only twelve registers.
// R2: receive registers refresh at every multiframe boundary, always on.
// R3: enable bits pick channels for change indication; three regs in T1.
// R4: integration reports change only after three stable multiframes.
// R5: change on an enabled channel sets status bit; with mask set, interrupt output goes low.
// R6: change-information bits record every change, enables ignored.
// R7: per-channel signaling stream on pin; serial data left intact.
// R8: elastic store optional; backplane clock 1.544 or 2.048 MHz.
// R9: ESF puts ABCD in low nibble, updated per multiframe.
// R10: D4 puts AB twice in low nibble, updated per multiframe.
// R11: reinsertion aligns to external multiframe sync on the sync pin.
// R12: reinsert on channels chosen in per-channel data when selected.
// R13: E1 global reinsert bit reinserts all channels.
// R14: T1 forces robbed-bit positions to one on selected channels.
// R15: with freeze enable, buffer holds on out-of-frame, loss or slip.
// R16: force-freeze freezes output regardless of freeze enable.
// R17: freeze indicator pin high while any freeze is in effect.
// R18: four-multiframe buffer gives three-multiframe delay.
// R19: after condition clears hold old state 9ms, 4.5ms in D4.
// R20: T1 force-all-ones drives all signaling to ones; no effect in E1.
// R21: receive order bit selects CAS or CCS register placement.
// R22: transmit order bit selects CAS or CCS for transmit signaling.
// R23: change-information bits stay set until their register is read.
// R24: channel change interrupts only when its enable bit is set.
// R25: control bits 5 and 6 reset to zero and do nothing.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`include "rsu_params.svh"

module rsu_receive_signaling #(
  parameter int P_HOLD_ESF_CYC = `RSU_HOLD_ESF_US * `RSU_CLK_MHZ,
  parameter int P_HOLD_D4_CYC  = `RSU_HOLD_D4_US * `RSU_CLK_MHZ
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_mf_start,
  input  wire logic        i_sig_valid,
  input  wire logic [4:0]  i_sig_idx,
  input  wire logic [7:0]  i_sig_byte,
  input  wire logic        i_out_of_frame,
  input  wire logic        i_carrier_loss,
  input  wire logic        i_slip,
  input  wire logic        i_rx_backplane_clk,
  input  wire logic        i_rx_sync_pin,
  input  wire logic        i_rx_serial_in,
  output logic             o_rx_sig_pin,
  output logic             o_rx_serial_out,
  output logic             o_freeze_indicator_pin,
  output logic             o_int_n,
  output logic             o_tx_sig_order
);

  // ===================================================================
  // helpers
  function automatic logic [3:0] nib_of(input logic [119:0] v,
                                        input logic [4:0]   c);
    nib_of = (c < 5'd30) ? v[{c, 2'b00} +: 4] : 4'h0;
  endfunction

  function automatic logic [7:0] byte_of(input logic [31:0] v,
                                         input logic [1:0]  k);
    byte_of = v[{k, 3'b000} +: 8];
  endfunction

  // ===================================================================
  // registers
  logic [7:0]   sigctl;
  logic [7:0]   cfg;
  logic [7:0]   pcptr;
  logic [31:0]  cos_en;
  logic [31:0]  cos_info;
  logic [31:0]  reins_mask;
  logic [31:0]  ones_mask;
  logic         cos_status;
  logic         cos_irq_mask;
  logic [119:0] cur_v;
  logic [7:0]   cur_f0;
  logic [119:0] rxs_v;
  logic [7:0]   rx_f0;
  logic [119:0] buf_q [4];
  logic [1:0]   wr_ptr;
  logic [119:0] pres_v;
  logic [21:0]  hold_cnt;
  rsu_pkg::rsu_frz_t frz_state;
  logic [29:0]  cap_en;
  logic [119:0] cap_v;
  logic [29:0]  chg;

  wire t1         = cfg[`RSU_B_T1];
  wire esf        = cfg[`RSU_B_ESF];
  wire integ      = cfg[`RSU_B_INTEG];
  wire bp2048     = cfg[`RSU_B_BP2048];
  wire all_ones   = t1 & sigctl[`RSU_B_ALL_ONES];                  // R20
  wire rx_order   = sigctl[`RSU_B_RX_ORDER];
  wire force_frz  = sigctl[`RSU_B_FORCE_FRZ];
  wire frz_en     = sigctl[`RSU_B_FRZ_EN];
  wire glob_reins = ~t1 & sigctl[`RSU_B_GLOB_REINS];               // R13
  assign o_tx_sig_order = sigctl[`RSU_B_TX_ORDER];                 // R22

  // ===================================================================
  // APB decode
  wire [6:0] idx      = i_paddr[8:2];
  wire       in_range = (i_paddr[11:9] == 3'h0) &&
                        (i_paddr[1:0] == 2'h0);
  wire [6:0] d_info   = idx - `RSU_IDX_COS_INFO;
  wire [6:0] d_en     = idx - `RSU_IDX_COS_EN;
  wire [6:0] d_pcd    = idx - `RSU_IDX_PCDATA;
  wire [6:0] d_rxs    = idx - `RSU_IDX_RX_SIG;
  wire sel_info   = in_range && (d_info < 7'd4);
  wire sel_en     = in_range && (d_en < 7'd4);
  wire sel_pcd    = in_range && (d_pcd < 7'd4);
  wire sel_rxs    = in_range && (d_rxs < 7'd16);
  wire sel_ctl    = in_range && (idx == `RSU_IDX_SIGCTL);
  wire sel_ptr    = in_range && (idx == `RSU_IDX_PCPTR);
  wire sel_stat   = in_range && (idx == `RSU_IDX_STATUS);
  wire sel_mask   = in_range && (idx == `RSU_IDX_MASK);
  wire sel_cfg    = in_range && (idx == `RSU_IDX_CONFIG);
  wire hit = sel_info | sel_en | sel_pcd | sel_rxs | sel_ctl |
             sel_ptr | sel_stat | sel_mask | sel_cfg;
  wire acc      = i_psel & i_penable;
  wire wr       = acc & i_pwrite & hit;
  wire rd       = acc & ~i_pwrite & hit;
  wire [7:0] wbyte = i_pwdata[7:0];
  // byte 3 of channel maps holds only channels 25 to 30
  wire [7:0] ch_bmask = ((sel_pcd ? d_pcd[1:0] : d_en[1:0]) == 2'd3) ?
                        8'h3f : 8'hff;

  assign o_pready  = 1'b1;
  assign o_pslverr = acc & ~hit;

  // receive signaling register view
  wire [3:0] r   = d_rxs[3:0];
  wire [4:0] r2  = {r, 1'b0};
  wire [4:0] r1  = {1'b0, r};
  wire [7:0] rs_t1  = (r < 4'd12) ?                                // R1
                      {nib_of(rxs_v, r2 + 5'd1), nib_of(rxs_v, r2)} :
                      8'h00;
  wire [7:0] rs_cas = (r == 4'd0) ? {4'h0, rx_f0[3:0]} :
                      {nib_of(rxs_v, r2 - 5'd1), nib_of(rxs_v, r2 - 5'd2)};
  wire [7:0] rs_ccs = (r == 4'd0) ? rx_f0 :
                      {nib_of(rxs_v, r1 - 5'd1), nib_of(rxs_v, r1 + 5'd14)};
  wire [7:0] rs_byte = t1 ? rs_t1 : (rx_order ? rs_ccs : rs_cas);  // R21
  wire [31:0] pcd_src = pcptr[`RSU_B_REINS_SEL] ? reins_mask : ones_mask;

  wire [7:0] rdata =
      sel_info ? byte_of(cos_info, d_info[1:0]) :
      sel_en   ? byte_of(cos_en, d_en[1:0]) :
      sel_pcd  ? byte_of(pcd_src, d_pcd[1:0]) :
      sel_rxs  ? rs_byte :
      sel_ctl  ? sigctl :
      sel_ptr  ? pcptr :
      sel_stat ? {7'h00, cos_status} :
      sel_mask ? {7'h00, cos_irq_mask} :
      sel_cfg  ? cfg : 8'h00;

  // read data launched in the setup phase, so zero-wait access works
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel & ~i_penable) begin
      o_prdata <= {24'h000000, rdata};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sigctl       <= `RSU_SIGCTL_RST;                             // R25
      cfg          <= `RSU_CFG_RST;
      pcptr        <= 8'h00;
      cos_en       <= 32'h00000000;
      reins_mask   <= 32'h00000000;
      ones_mask    <= 32'h00000000;
      cos_irq_mask <= 1'b0;
    end else if (wr) begin
      if (sel_ctl) begin
        sigctl <= wbyte & `RSU_SIGCTL_WMASK;                       // R25
      end
      if (sel_cfg) begin
        cfg <= {4'h0, wbyte[3:0]};
      end
      if (sel_ptr) begin
        pcptr <= {6'h00, wbyte[1:0]};
      end
      if (sel_mask) begin
        cos_irq_mask <= wbyte[0];
      end
      if (sel_en) begin
        cos_en[{d_en[1:0], 3'b000} +: 8] <= wbyte & ch_bmask;      // R3
      end
      if (sel_pcd && pcptr[`RSU_B_REINS_SEL]) begin
        reins_mask[{d_pcd[1:0], 3'b000} +: 8] <= wbyte & ch_bmask; // R12
      end
      if (sel_pcd && pcptr[`RSU_B_ONES_SEL]) begin
        ones_mask[{d_pcd[1:0], 3'b000} +: 8] <= wbyte & ch_bmask;  // R14
      end
    end
  end

  // ===================================================================
  // capture of channel signaling from the framer
  wire [3:0] t1_nib = esf ? i_sig_byte[3:0] :                      // R9
                      {i_sig_byte[3:2], i_sig_byte[3:2]};          // R10

  for (genvar c = 0; c < 30; c++) begin : g_ch
    localparam logic [4:0] CH = 5'(c);
    localparam logic [4:0] FR = 5'(c < 15 ? c + 1 : c - 14);
    assign cap_en[c] = i_sig_valid &&
                       (t1 ? (c < 24 && i_sig_idx == CH) :         // R1
                             (i_sig_idx == FR));
    assign cap_v[4*c +: 4] = t1 ? t1_nib :
                             (c < 15 ? i_sig_byte[7:4] : i_sig_byte[3:0]);
    rsu_cos_chan u_cos (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_mf     (i_mf_start),
      .i_integ  (integ),                                           // R4
      .i_new    (cur_v[4*c +: 4]),
      .o_change (chg[c])
    );
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cur_v  <= '0;
      cur_f0 <= 8'h00;
    end else if (i_sig_valid) begin
      cur_v <= (cur_v & ~expand(cap_en)) | (cap_v & expand(cap_en));
      if (!t1 && i_sig_idx == 5'd0) begin
        cur_f0 <= i_sig_byte;
      end
    end
  end

  function automatic logic [119:0] expand(input logic [29:0] e);
    for (int k = 0; k < 30; k++) begin
      expand[4*k +: 4] = {4{e[k]}};
    end
  endfunction

  // registers refresh at every boundary, whatever the freeze state
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rxs_v <= '0;
      rx_f0 <= 8'h00;
    end else if (i_mf_start) begin
      rxs_v <= cur_v;                                              // R2
      rx_f0 <= cur_f0;                                             // R2
    end
  end

  // ===================================================================
  // change of state: info, status, interrupt
  wire [31:0] en_eff  = t1 ? (cos_en & `RSU_T1_CH_MASK) : cos_en;  // R3
  wire [31:0] chg_w   = {2'b00, chg};
  wire [31:0] info_clr = (rd && sel_info) ?
                         (32'(o_prdata[7:0]) << {d_info[1:0], 3'b000}) :
                         32'h00000000;
  wire [31:0] next_info = (cos_info & ~info_clr) | chg_w;          // R23
  wire        cos_evt   = |(chg_w & en_eff);                       // R24
  wire        next_stat = (cos_status & ~(rd & sel_stat & o_prdata[0])) |
                          cos_evt;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cos_info   <= 32'h00000000;
      cos_status <= 1'b0;
    end else begin
      cos_info   <= next_info;                                     // R6
      cos_status <= next_stat;                                     // R5
    end
  end

  assign o_int_n = ~(cos_status & cos_irq_mask);                   // R5

  // ===================================================================
  // freeze control
  wire frz_cond = frz_en & (i_out_of_frame | i_carrier_loss | i_slip);
  wire [21:0] hold_load = (t1 && !esf) ? 22'(P_HOLD_D4_CYC) :
                                         22'(P_HOLD_ESF_CYC);
  wire frozen = force_frz | (frz_state != rsu_pkg::RSU_RUN);       // R16

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      frz_state <= rsu_pkg::RSU_RUN;
      hold_cnt  <= 22'd0;
    end else begin
      case (frz_state)
        rsu_pkg::RSU_RUN: begin
          if (frz_cond) begin
            frz_state <= rsu_pkg::RSU_FROZEN;                      // R15
          end
        end
        rsu_pkg::RSU_FROZEN: begin
          if (!frz_cond) begin
            frz_state <= rsu_pkg::RSU_HOLD;
            hold_cnt  <= hold_load;                                // R19
          end
        end
        rsu_pkg::RSU_HOLD: begin
          if (frz_cond) begin
            frz_state <= rsu_pkg::RSU_FROZEN;
          end else if (hold_cnt <= 22'd1) begin
            frz_state <= rsu_pkg::RSU_RUN;
          end else begin
            hold_cnt <= hold_cnt - 22'd1;                          // R19
          end
        end
        default: begin
          frz_state <= rsu_pkg::RSU_RUN;
        end
      endcase
    end
  end

  assign o_freeze_indicator_pin = frozen;                          // R17

  // four slots; a frozen buffer neither writes nor advances
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_ptr <= 2'd0;
      for (int k = 0; k < 4; k++) begin
        buf_q[k] <= '0;
      end
    end else if (i_mf_start && !frozen) begin                      // R15
      buf_q[wr_ptr] <= cur_v;
      wr_ptr        <= wr_ptr + 2'd1;
    end
  end

  // second-oldest slot: two boundaries behind the newest
  wire [1:0] rd_ptr = wr_ptr + 2'd1;                               // R18

  // ===================================================================
  // backplane side, sampled on i_clk
  logic [2:0] bp_s;
  logic       bp_clk_d;
  logic [7:0] pos;
  logic [4:0] frm;

  rsu_sync2 #(.P_W(3)) u_sync (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    ({i_rx_serial_in, i_rx_sync_pin, i_rx_backplane_clk}),
    .o_q    (bp_s)
  );

  wire bp_rise = bp_s[0] & ~bp_clk_d;
  // 193-bit frame only for T1 on a 1.544 MHz backplane
  wire       short_fr = t1 & ~bp2048;                              // R8
  wire [7:0] last_pos = short_fr ? `RSU_LEN_T1 : `RSU_LEN_2048;
  wire [4:0] last_frm = !t1 ? `RSU_MF_E1 :
                        esf ? `RSU_MF_ESF : `RSU_MF_D4;
  wire       fr_end   = (pos == last_pos);
  wire [7:0] npos = bp_s[1] ? 8'd0 : (fr_end ? 8'd0 : pos + 8'd1); // R11
  wire [4:0] nfrm = bp_s[1] ? 5'd0 :
                    !fr_end ? frm :
                    (frm == last_frm) ? 5'd0 : frm + 5'd1;

  wire [7:0] bpos    = short_fr ? npos - 8'd1 : npos;
  wire [4:0] ts      = bpos[7:3];
  wire [2:0] bitc    = bpos[2:0];
  wire       f_bit   = short_fr && npos == 8'd0;
  wire       e1_slot = !t1 && ts == 5'd16 && nfrm != 5'd0;
  wire       chan_ok = !f_bit && (t1 ? ts < 5'd24 :
                       (ts != 5'd0 && ts != 5'd16));
  wire [4:0] ch      = t1 ? ts : (ts < 5'd16 ? ts - 5'd1 : ts - 5'd2);
  wire [4:0] sel_ch  = !e1_slot ? ch :
                       bitc[2] ? nfrm + 5'd14 : nfrm - 5'd1;
  wire       force1  = all_ones | (t1 & ones_mask[sel_ch]);        // R14
  wire [3:0] pn      = force1 ? 4'hf : nib_of(pres_v, sel_ch);     // R20
  wire       reins   = glob_reins | reins_mask[sel_ch];            // R12
  wire [1:0] grp     = (nfrm >= 5'd18) ? 2'd3 : (nfrm >= 5'd12) ? 2'd2 :
                       (nfrm >= 5'd6) ? 2'd1 : 2'd0;
  // robbed-bit frames 6, 12 (and 18, 24 in ESF), bit 8 of each channel
  wire       robbed  = t1 && chan_ok && bitc == 3'd7 &&
                       (nfrm == 5'd5 || nfrm == 5'd11 ||
                        (esf && (nfrm == 5'd17 || nfrm == 5'd23)));
  wire       sig_bit = pn[~bitc[1:0]];
  wire       rx_sig_pin_nx = chan_ok & bitc[2] & sig_bit;                // R7
  // original signaling passes through unless reinserted or forced
  wire       ser_nx  = (robbed && (force1 || reins)) ? pn[~grp] :  // R11
                       (e1_slot && reins) ? sig_bit :              // R13
                       bp_s[2];                                    // R7

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bp_clk_d        <= 1'b0;
      pos             <= 8'd0;
      frm             <= 5'd0;
      pres_v          <= '0;
      o_rx_sig_pin    <= 1'b0;
      o_rx_serial_out <= 1'b0;
    end else begin
      bp_clk_d <= bp_s[0];
      if (bp_rise) begin
        pos             <= npos;
        frm             <= nfrm;
        o_rx_sig_pin    <= rx_sig_pin_nx;                                // R7
        o_rx_serial_out <= ser_nx;
        if (npos == 8'd0 && nfrm == 5'd0) begin
          pres_v <= buf_q[rd_ptr];                                 // R18
        end
      end
    end
  end

endmodule

// ### testbench/rsu_backplane_model.sv
// rsu_backplane_model: backplane clock, multiframe sync, serial data.
// assumes: clock runs free; sync is high for one bit per multiframe.
`timescale 1ns/100ps
module rsu_backplane_model #(
  parameter int P_MF_BITS = 4632
) (
  output logic o_bclk,
  output logic o_sync,
  output logic o_ser
);
  int pos = 0;
  initial begin
    o_bclk = 1'b0;
    o_sync = 1'b0;
    o_ser  = 1'b0;
    forever begin
      #24 o_bclk = ~o_bclk;
      // move on the falling edge so the rising edge sees settled data
      if (!o_bclk) begin
        pos = (pos + 1) % P_MF_BITS;
        o_sync = (pos == 0);
        o_ser = ~o_ser;
      end
    end
  end
endmodule

// ### testbench/rsu_checker.sv
// rsu_checker: port-level properties of the receive signaling unit.
// assumes: bound to rsu_receive_signaling; one clock domain.
`timescale 1ns/100ps
module rsu_checker (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_mf_start,
  input wire logic        i_out_of_frame,
  input wire logic        o_freeze_indicator_pin,
  input wire logic        o_int_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire  acc    = i_psel && i_penable;
  wire  wr_acc = acc && i_pwrite;
  logic frz_en;
  logic msk;
  // ==================================================================
  // shadow of control bits
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      frz_en <= 1'b0;
      msk    <= 1'b0;
    end else if (wr_acc && i_paddr == 12'h100) begin
      frz_en <= i_pwdata[4];
    end else if (wr_acc && i_paddr == 12'h158) begin
      msk <= i_pwdata[0];
    end
  end
  // ==================================================================
  // properties
  sequence s_ctl_wr;
    wr_acc && i_paddr == 12'h100;
  endsequence
  sequence s_oof_end;
    o_freeze_indicator_pin && $fell(i_out_of_frame);
  endsequence
  chk_int_cause: assert property ($fell(o_int_n) |->
    $past(i_mf_start) || $past(i_mf_start, 2) || $past(wr_acc))
    else $error("interrupt without a cause");
  chk_int_mask: assert property (!o_int_n |-> msk)
    else $error("interrupt while masked");
  chk_int_release: assert property ($rose(o_int_n) |-> $past(acc))
    else $error("interrupt cleared without access");
  chk_force_frz: assert property (s_ctl_wr ##0 i_pwdata[3]
    |=> o_freeze_indicator_pin) else $error("force freeze missed");
  chk_oof_frz: assert property (frz_en && i_out_of_frame
    |-> ##[0:3] o_freeze_indicator_pin) else $error("no freeze");
  chk_frz_hold: assert property (s_oof_end
    |-> o_freeze_indicator_pin [*8]) else $error("hold too short");
  chk_bad_addr: assert property (acc && i_paddr == 12'hffc
    |-> o_pslverr && o_pready) else $error("unmapped not refused");
  chk_ctl_ok: assert property (s_ctl_wr |-> !o_pslverr)
    else $error("control write refused");
  chk_rdata_hold: assert property (acc ##1 !i_psel
    |-> $stable(o_prdata)) else $error("read data moved");
endmodule

bind rsu_receive_signaling rsu_checker i_rsu_checker (
  .i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_prdata, .o_pready, .o_pslverr, .i_mf_start, .i_out_of_frame,
  .o_freeze_indicator_pin, .o_int_n);

// ### testbench/test_rsu_receive_signaling.sv
// test_rsu_receive_signaling: register, capture, change and freeze tests.
// assumes: hold counters shortened to 50 and 25 cycles.
`timescale 1ns/100ps
module test_rsu_receive_signaling;
  logic        i_clk, i_nrst, psel, penable, pwrite, mf, sv;
  logic        out_of_frame, closs, slip, bclk, sync, ser, sig_pin, frz, int_n;
  logic        tx_ord, pready, pslverr, last_err, sout;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, ones;
  logic [4:0]  sidx;
  logic [7:0]  sbyte;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  rsu_receive_signaling #(.P_HOLD_ESF_CYC(50), .P_HOLD_D4_CYC(25))
  i_rsu_receive_signaling (.i_clk, .i_nrst, .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_mf_start(mf), .i_sig_valid(sv),
    .i_sig_idx(sidx), .i_sig_byte(sbyte), .i_out_of_frame(out_of_frame),
    .i_carrier_loss(closs), .i_slip(slip), .i_rx_backplane_clk(bclk),
    .i_rx_sync_pin(sync), .i_rx_serial_in(ser), .o_rx_sig_pin(sig_pin),
    .o_rx_serial_out(sout), .o_freeze_indicator_pin(frz),
    .o_int_n(int_n), .o_tx_sig_order(tx_ord));
  rsu_backplane_model i_rsu_backplane_model (.o_bclk(bclk),
    .o_sync(sync), .o_ser(ser));

  // ==================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic mfr(input logic [4:0] i, input logic [7:0] b);
    @(posedge i_clk);
    sv <= 1'b1;
    sidx <= i;
    sbyte <= b;
    @(posedge i_clk);
    sv <= 1'b0;
    mf <= 1'b1;
    @(posedge i_clk);
    mf <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==================================================================
  // clock, timeout, tests
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    {i_nrst, psel, penable, pwrite, mf, sv, out_of_frame, closs, slip} = '0;
    {paddr, pwdata, sidx, sbyte} = '0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(12'h100, 32'h0);
    apb(1'b1, 12'h100, 32'h62);
    rd(12'h100, 32'h02);
    check(tx_ord, 1'b1);
    apb(1'b1, 12'h100, 32'h0);
    rd(12'hffc, 32'h0);
    check(last_err, 1'b1);
    $display("test registers done");
    apb(1'b1, 12'h158, 32'h1);
    mfr(5'd1, 8'ha5);
    rd(12'h184, 32'h0a);
    rd(12'h1a0, 32'h50);
    check(int_n, 1'b1);
    rd(12'h0e0, 32'h01);
    rd(12'h0e4, 32'h80);
    rd(12'h0e0, 32'h00);
    apb(1'b1, 12'h100, 32'h4);
    mfr(5'd1, 8'ha5);
    rd(12'h184, 32'ha5);
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b1, 12'h0f0, 32'h1);
    mfr(5'd1, 8'h35);
    check(int_n, 1'b0);
    rd(12'h154, 32'h01);
    #1 check(int_n, 1'b1);
    $display("test capture done");
    apb(1'b1, 12'h15c, 32'h4);
    rd(12'h0e0, 32'h01);
    repeat (2) mfr(5'd1, 8'h75);
    rd(12'h0e0, 32'h00);
    mfr(5'd1, 8'h75);
    rd(12'h0e0, 32'h01);
    $display("test integration done");
    apb(1'b1, 12'h100, 32'h8);
    #1 check(frz, 1'b1);
    apb(1'b1, 12'h100, 32'h0);
    repeat (60) @(posedge i_clk);
    out_of_frame <= 1'b1;
    repeat (4) @(posedge i_clk);
    check(frz, 1'b0);
    out_of_frame <= 1'b0;
    apb(1'b1, 12'h100, 32'h10);
    for (int k = 0; k < 3; k++) begin
      {slip, closs, out_of_frame} <= 3'b001 << k;
      repeat (4) @(posedge i_clk);
      check(frz, 1'b1);
      {slip, closs, out_of_frame} <= 3'b000;
      repeat (20) @(posedge i_clk);
      check(frz, 1'b1);
      repeat (60) @(posedge i_clk);
      check(frz, 1'b0);
    end
    $display("test freeze done");
    @(posedge bclk) q = ser;
    @(negedge bclk) check(sout, q);
    apb(1'b1, 12'h100, 32'h1);
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 12'h15c, c ? 32'h1 : 32'h3);
      repeat (70) @(negedge bclk);
      ones = '0;
      repeat (193) begin
        @(negedge bclk);
        ones += sig_pin;
      end
      check(ones, 32'd96);
    end
    $display("test all ones done");
    print_verdict();
  end
endmodule
